// File: core/mnx_decode.sv
`timescale 1ns/10ps

module mnx_decode (
	input  wire logic [mnx_pkg::INSTR_W-1:0] word,
	output mnx_pkg::mnx_op_t                 op,
	output logic [mnx_pkg::FIDX_W-1:0]       fidx,
	output logic                             dest,
	output logic [mnx_pkg::DATA_W-1:0]       lit
);
	import mnx_pkg::*;

	wire is_copy  = (word & COPY_MSK) == COPY_VAL;
	wire is_store = (word & STORE_MSK) == STORE_VAL;
	wire is_lit   = (word & LIT_MSK) == LIT_VAL;
	wire is_idle  = word == IDLE_WORD;
	wire is_opt   = word == OPT_WORD;

	assign fidx = word[FIDX_W-1:0];
	assign dest = word[DEST_BIT];
	assign lit  = word[DATA_W-1:0];

	always_comb begin
		if (is_copy)
			op = OP_COPY;
		else if (is_store)
			op = OP_STORE;
		else if (is_lit)
			op = OP_LOADLIT;
		else if (is_opt)
			op = OP_OPTLOAD;
		else if (is_idle)
			op = OP_IDLE;
		else
			op = OP_OTHER;
	end

endmodule : mnx_decode

// File: core/mnx_exec.sv
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/10ps

// Functional notes
// RULE1 - A copy-file word reads the file register named by its 5-bit index and moves that value to its destination.
// RULE2 - For a copy-file word a destination bit of 0 loads the accumulator and 1 writes the register back.
// RULE3 - A copy-file word sets the zero flag from the moved value, also when it goes back to its own register.
// RULE4 - A store-accumulator word writes the accumulator into the indexed file register and leaves every flag alone.
// RULE5 - The fixed word ending in 0010 copies the accumulator into the timer/prescaler setup register, no flags.
// RULE6 - Load-literal puts its byte in the accumulator, no flags; the zero word idles; each word takes one cycle.
module mnx_exec #(
	parameter int unsigned FILE_N = mnx_pkg::FILE_N
) (
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [mnx_pkg::ADDR_W-1:0]    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic                          instr_valid,
	input  wire logic [mnx_pkg::INSTR_W-1:0]   instr_word,
	output logic                               fetch_ready,
	output logic      [mnx_pkg::DATA_W-1:0]    acc_out,
	output logic                               zero_out,
	output logic      [mnx_pkg::DATA_W-1:0]    option_out
);
	import mnx_pkg::*;

	function automatic logic is_zero(input logic [DATA_W-1:0] v);
		return v == '0;
	endfunction : is_zero

	////////////////////////////////////////////////////////////////////////////
	// State
	logic [DATA_W-1:0]  file_r [FILE_N];
	logic [DATA_W-1:0]  acc_r;
	logic               zero_r;
	logic [DATA_W-1:0]  opt_r;
	logic               unsup_r;
	logic [CNT_W-1:0]   cnt_r;
	logic [INSTR_W-1:0] last_r;
	logic               fetch_ready_r;
	logic               pready_r;
	logic               pslverr_r;
	logic [31:0]        prdata_r;

	////////////////////////////////////////////////////////////////////////////
	// Bus decode
	wire                apb_done  = psel & penable & pready_r;
	wire                apb_wr    = apb_done & pwrite;
	wire                sel_exec  = paddr == OFS_EXEC;
	wire                sel_acc   = paddr == OFS_ACC;
	wire                sel_stat  = paddr == OFS_STAT;
	wire                sel_opt   = paddr == OFS_OPT;
	wire                sel_cnt   = paddr == OFS_CNT;
	wire                sel_file  = ((paddr & FILE_AREA_MSK) == OFS_FILE_BASE) && (paddr[1:0] == 2'b00);
	wire [FIDX_W-1:0]   bus_fidx  = paddr[FIDX_W+1:2];
	wire                sel_known = sel_exec | sel_acc | sel_stat | sel_opt | sel_cnt | sel_file;

	wire                wr_exec   = apb_wr & sel_exec;
	wire                wr_acc    = apb_wr & sel_acc;
	wire                wr_stat   = apb_wr & sel_stat;
	wire                wr_cnt    = apb_wr & sel_cnt;
	wire                wr_file   = apb_wr & sel_file;

	////////////////////////////////////////////////////////////////////////////
	// Instruction source: fetch port, or a bus write to the execute register.
	// Any bus access stalls fetch, so the two never meet on one edge.
	wire                fetch_go  = instr_valid & fetch_ready_r;
	wire                exec_go   = fetch_go | wr_exec;
	wire [INSTR_W-1:0]  exec_word = wr_exec ? pwdata[INSTR_W-1:0] : instr_word;

	mnx_op_t            dec_op;
	logic [FIDX_W-1:0]  dec_fidx;
	logic               dec_dest;
	logic [DATA_W-1:0]  dec_lit;

	mnx_decode u_decode (
		.word (exec_word),
		.op   (dec_op),
		.fidx (dec_fidx),
		.dest (dec_dest),
		.lit  (dec_lit)
	);

	wire                do_copy   = exec_go & (dec_op == OP_COPY);
	wire                do_store  = exec_go & (dec_op == OP_STORE);
	wire                do_lit    = exec_go & (dec_op == OP_LOADLIT);
	wire                do_opt    = exec_go & (dec_op == OP_OPTLOAD);
	wire                do_other  = exec_go & (dec_op == OP_OTHER);

	wire [DATA_W-1:0]   copy_val  = file_r[dec_fidx];                  // RULE1
	wire                copy_to_f = do_copy & dec_dest;                // RULE2
	wire                copy_to_w = do_copy & ~dec_dest;               // RULE2

	////////////////////////////////////////////////////////////////////////////
	// Next values
	logic [DATA_W-1:0]  acc_nxt;
	logic               zero_nxt;
	logic [DATA_W-1:0]  opt_nxt;
	logic               unsup_nxt;
	logic [CNT_W-1:0]   cnt_nxt;
	logic               file_we;
	logic [FIDX_W-1:0]  file_wa;
	logic [DATA_W-1:0]  file_wd;

	always_comb begin
		acc_nxt = acc_r;
		if (copy_to_w)
			acc_nxt = copy_val;                                        // RULE2
		else if (do_lit)
			acc_nxt = dec_lit;                                         // RULE6
		else if (wr_acc)
			acc_nxt = pwdata[DATA_W-1:0];
	end

	// Only the copy-file word touches the zero flag
	assign zero_nxt = do_copy ? is_zero(copy_val) : zero_r;            // RULE3

	assign opt_nxt = do_opt ? acc_r : opt_r;                           // RULE5

	// A new unsupported word wins over a clear in the same cycle
	assign unsup_nxt = do_other | (unsup_r & ~(wr_stat & pwdata[STAT_UNSUP_BIT]));

	always_comb begin
		cnt_nxt = cnt_r;
		if (wr_cnt)
			cnt_nxt = '0;
		if (exec_go & ~do_other)
			cnt_nxt = cnt_nxt + CNT_W'(1);                             // RULE6
	end

	always_comb begin
		file_we = 1'b0;
		file_wa = dec_fidx;
		file_wd = acc_r;
		if (do_store) begin
			file_we = 1'b1;                                            // RULE4
		end else if (copy_to_f) begin
			file_we = 1'b1;
			file_wd = copy_val;                                        // RULE2
		end else if (wr_file) begin
			file_we = 1'b1;
			file_wa = bus_fidx;
			file_wd = pwdata[DATA_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data
	logic [31:0] rd_val;

	always_comb begin
		rd_val = '0;
		if (sel_exec)
			rd_val[INSTR_W-1:0] = last_r;
		else if (sel_acc)
			rd_val[DATA_W-1:0] = acc_r;
		else if (sel_stat) begin
			rd_val[STAT_ZERO_BIT]  = zero_r;
			rd_val[STAT_UNSUP_BIT] = unsup_r;
		end else if (sel_opt)
			rd_val[DATA_W-1:0] = opt_r;
		else if (sel_cnt)
			rd_val[CNT_W-1:0] = cnt_r;
		else if (sel_file)
			rd_val[DATA_W-1:0] = file_r[bus_fidx];
	end

	wire pready_nxt = psel & penable & ~pready_r & ~fetch_ready_r;

	////////////////////////////////////////////////////////////////////////////
	// Flip-flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_r   <= ACC_RST;
			zero_r  <= 1'b0;
			opt_r   <= OPT_RST;
			unsup_r <= 1'b0;
			cnt_r   <= '0;
			last_r  <= LAST_RST;
		end else begin
			acc_r   <= acc_nxt;
			zero_r  <= zero_nxt;
			opt_r   <= opt_nxt;
			unsup_r <= unsup_nxt;
			cnt_r   <= cnt_nxt;
			if (exec_go)
				last_r <= exec_word;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < FILE_N; i++)
				file_r[i] <= FILE_RST;
		end else if (file_we) begin
			file_r[file_wa] <= file_wd;
		end
	end

	// Fetch is held off from the cycle after psel rises to the cycle after it falls, so every bus effect lands alone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fetch_ready_r <= 1'b1;
			pready_r      <= 1'b0;
			pslverr_r     <= 1'b0;
			prdata_r      <= '0;
		end else begin
			fetch_ready_r <= ~psel;
			pready_r      <= pready_nxt;
			if (pready_nxt) begin
				pslverr_r <= ~sel_known;
				prdata_r  <= pwrite ? 32'h0000_0000 : rd_val;
			end else begin
				pslverr_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign prdata      = prdata_r;
	assign pready      = pready_r;
	assign pslverr     = pslverr_r;
	assign fetch_ready = fetch_ready_r;
	assign acc_out     = acc_r;
	assign zero_out    = zero_r;
	assign option_out  = opt_r;

endmodule : mnx_exec

// File: core/mnx_pkg.sv
package mnx_pkg;

	localparam int unsigned DATA_W   = 8;
	localparam int unsigned INSTR_W  = 12;
	localparam int unsigned FIDX_W   = 5;
	localparam int unsigned FILE_N   = 32;
	localparam int unsigned ADDR_W   = 12;
	localparam int unsigned CNT_W    = 16;

	////////////////////////////////////////////////////////////////////////////
	// Register offsets, byte addresses
	localparam logic [ADDR_W-1:0] OFS_EXEC      = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_ACC       = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_STAT      = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_OPT       = 12'h00C;
	localparam logic [ADDR_W-1:0] OFS_CNT       = 12'h010;
	localparam logic [ADDR_W-1:0] OFS_FILE_BASE = 12'h080;
	localparam logic [ADDR_W-1:0] FILE_AREA_MSK = 12'hF80;

	// Status register fields
	localparam int unsigned STAT_ZERO_BIT  = 0;
	localparam int unsigned STAT_UNSUP_BIT = 1;

	// Values after reset
	localparam logic [DATA_W-1:0]  ACC_RST  = 8'h00;
	localparam logic [DATA_W-1:0]  OPT_RST  = 8'hFF;
	localparam logic [DATA_W-1:0]  FILE_RST = 8'h00;
	localparam logic [INSTR_W-1:0] LAST_RST = 12'h000;

	////////////////////////////////////////////////////////////////////////////
	// Instruction encodings: a word matches when (word & mask) == value, or when it equals IDLE_WORD or OPT_WORD
	localparam logic [INSTR_W-1:0] COPY_MSK  = 12'hFC0;
	localparam logic [INSTR_W-1:0] COPY_VAL  = 12'h200;
	localparam logic [INSTR_W-1:0] STORE_MSK = 12'hFE0;
	localparam logic [INSTR_W-1:0] STORE_VAL = 12'h020;
	localparam logic [INSTR_W-1:0] LIT_MSK   = 12'hF00;
	localparam logic [INSTR_W-1:0] LIT_VAL   = 12'hC00;
	localparam logic [INSTR_W-1:0] IDLE_WORD = 12'h000;
	localparam logic [INSTR_W-1:0] OPT_WORD  = 12'h002;
	localparam int unsigned        DEST_BIT  = 5;

	typedef enum logic [2:0] {
		OP_IDLE,
		OP_COPY,
		OP_LOADLIT,
		OP_STORE,
		OP_OPTLOAD,
		OP_OTHER
	} mnx_op_t;

endpackage : mnx_pkg

// File: dv/mnx_exec_chk.sv
`timescale 1ns/10ps

module mnx_exec_chk (
	input wire logic                          pclk,
	input wire logic                          presetn,
	input wire logic                          psel,
	input wire logic                          instr_valid,
	input wire logic [mnx_pkg::INSTR_W-1:0]   instr_word,
	input wire logic                          fetch_ready,
	input wire logic [mnx_pkg::DATA_W-1:0]    acc_out,
	input wire logic                          zero_out,
	input wire logic [mnx_pkg::DATA_W-1:0]    option_out
);
	import mnx_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire tk = instr_valid && fetch_ready;
	sequence s_lit; tk && instr_word[11:8] == 4'hC; endsequence
	sequence s_store; tk && instr_word[11:5] == 7'b0000001; endsequence
	sequence s_copy; tk && instr_word[11:6] == 6'b001000; endsequence
	property p_lit; s_lit |=> acc_out == $past(instr_word[7:0]) && $stable(zero_out); endproperty
	a_lit: assert property (p_lit) else $error("literal load wrong");
	property p_idle; tk && instr_word == 12'h000 |=> $stable(acc_out) && $stable(zero_out) && $stable(option_out); endproperty
	a_idle: assert property (p_idle) else $error("idle word changed state");
	property p_opt; tk && instr_word == 12'h002 |=> option_out == $past(acc_out) && $stable(zero_out); endproperty
	a_opt: assert property (p_opt) else $error("option load wrong");
	property p_store; s_store |=> $stable(acc_out) && $stable(zero_out) && $stable(option_out); endproperty
	a_store: assert property (p_store) else $error("store touched acc or flags");
	property p_copy_w; s_copy ##0 !instr_word[5] |=> zero_out == (acc_out == 8'h00); endproperty
	a_copy_w: assert property (p_copy_w) else $error("copy zero flag wrong");
	property p_copy_f; s_copy ##0 instr_word[5] |=> $stable(acc_out) && $stable(option_out); endproperty
	a_copy_f: assert property (p_copy_f) else $error("copy back touched acc");
	property p_st_cp; s_store ##1 s_copy ##0 instr_word[5:0] == {1'b0, $past(instr_word[4:0])}
		|=> acc_out == $past(acc_out, 2) && zero_out == ($past(acc_out, 2) == 8'h00); endproperty
	a_st_cp: assert property (p_st_cp) else $error("store then copy mismatch");
	property p_opt_src; !$stable(option_out) && !$past(psel) |-> $past(tk && instr_word == 12'h002); endproperty
	a_opt_src: assert property (p_opt_src) else $error("option changed without load");
	property p_z_src; !$stable(zero_out) && !$past(psel) |-> $past(tk && instr_word[11:6] == 6'b001000); endproperty
	a_z_src: assert property (p_z_src) else $error("zero changed without copy");
endmodule : mnx_exec_chk

bind mnx_exec mnx_exec_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .instr_valid(instr_valid),
	.instr_word(instr_word), .fetch_ready(fetch_ready), .acc_out(acc_out), .zero_out(zero_out),
	.option_out(option_out));

// File: dv/mnx_fetch_model.sv
`timescale 1ns/10ps

module mnx_fetch_model (
	input  wire logic        pclk,
	input  wire logic        fetch_ready,
	output logic             instr_valid,
	output logic [11:0]      instr_word
);
	initial begin
		instr_valid = 1'b0;
		instr_word = 12'hA5A;
	end
	// Holds the word until taken; a released bus shows the inverse, not a stale copy
	task automatic issue(input logic [11:0] w, input int gap);
		instr_valid <= 1'b1;
		instr_word <= w;
		do @(posedge pclk); while (fetch_ready !== 1'b1);
		if (gap > 0) begin
			instr_valid <= 1'b0;
			instr_word <= ~w;
			repeat (gap) @(posedge pclk);
		end
	endtask : issue
endmodule : mnx_fetch_model

// File: dv/move_and_nop_instruction_exec_bench.sv
`timescale 1ns/10ps

module move_and_nop_instruction_exec_bench;
	import mnx_pkg::*;
	logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, err, e_z, e_unsup;
	logic [CNT_W-1:0]    e_cnt;
	logic                instr_valid, fetch_ready, zero_out, pend = 1'b0;
	logic [ADDR_W-1:0]   paddr;
	logic [31:0]         pwdata, prdata, rd, r;
	logic [INSTR_W-1:0]  instr_word;
	logic [DATA_W-1:0]   acc_out, option_out, e_acc, e_opt, e_f [FILE_N];
	int                  bad_count, n_compared, k, seed = 32'h01c672b9;
	logic [INSTR_W-1:0]  corner [6] = '{12'h03F, 12'h21F, 12'hC00, 12'h002, 12'h23E, 12'hCFF};

	mnx_exec u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.instr_valid(instr_valid), .instr_word(instr_word), .fetch_ready(fetch_ready),
		.acc_out(acc_out), .zero_out(zero_out), .option_out(option_out));
	mnx_fetch_model u_fetch (.pclk(pclk), .fetch_ready(fetch_ready), .instr_valid(instr_valid),
		.instr_word(instr_word));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic summarize();
		if (bad_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize

	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	function automatic void model_exec(input logic [INSTR_W-1:0] w);
		logic [DATA_W-1:0] v;
		logic              sup;
		v = e_f[w[4:0]];
		sup = 1'b1;
		if (w == 12'h002) e_opt = e_acc;
		else if (w[11:8] == 4'hC) e_acc = w[7:0];
		else if (w[11:5] == 7'b0000001) e_f[w[4:0]] = e_acc;
		else if (w[11:6] == 6'b001000) begin
			e_z = (v == 8'h00);
			if (w[5]) e_f[w[4:0]] = v;
			else e_acc = v;
		end
		else if (w != 12'h000) begin
			sup = 1'b0;
			e_unsup = 1'b1;
		end
		if (sup) e_cnt = e_cnt + 16'h0001;
	endfunction : model_exec

	function automatic logic [INSTR_W-1:0] pick(input int kind, input logic [31:0] x);
		case (kind)
			0: return 12'h000;
			1: return 12'h002;
			2: return {4'hC, x[7:0]};
			3: return {7'b0000001, x[4:0]};
			4: return {6'b001000, x[5:0]};
			default: return 12'hFFF;
		endcase
	endfunction : pick

	// Results of a taken word are compared one edge later
	always @(posedge pclk) begin
		if (pend) begin
			chk(acc_out, e_acc);
			chk(zero_out, e_z);
			chk(option_out, e_opt);
		end
		pend = presetn && instr_valid && fetch_ready;
		if (pend) model_exec(instr_word);
	end

	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		summarize();
	end

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{e_acc, e_opt, e_z} = {ACC_RST, OPT_RST, 1'b0};
		e_unsup = 1'b0;
		e_cnt = '0;
		foreach (e_f[i]) e_f[i] = FILE_RST;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFS_OPT, 32'h0);
		chk(rd, {24'h0, OPT_RST});
		apb(1'b0, 12'h014, 32'h0);
		chk(err, 1'b1);
		apb(1'b1, OFS_ACC, 32'h5A);
		e_acc = 8'h5A;
		foreach (corner[i]) u_fetch.issue(corner[i], 0);
		repeat (400) begin
			k = $unsigned($random(seed)) % 6;
			r = $random(seed);
			u_fetch.issue(pick(k, r), int'(r[13:12]));
		end
		u_fetch.issue(12'h000, 2);
		// Words executed from the bus, then the status, count and option registers
		apb(1'b1, OFS_EXEC, 32'h0000_0C3C);
		model_exec(12'hC3C);
		apb(1'b1, OFS_EXEC, 32'h0000_0FFF);
		model_exec(12'hFFF);
		apb(1'b1, OFS_OPT, 32'h0000_0011);
		apb(1'b0, OFS_EXEC, 32'h0);
		chk(rd, 32'h0000_0FFF);
		apb(1'b0, OFS_ACC, 32'h0);
		chk(rd, {24'h0, e_acc});
		apb(1'b0, OFS_OPT, 32'h0);
		chk(rd, {24'h0, e_opt});
		apb(1'b0, OFS_STAT, 32'h0);
		chk(rd, {30'h0, e_unsup, e_z});
		apb(1'b0, OFS_CNT, 32'h0);
		chk(rd, {16'h0, e_cnt});
		apb(1'b1, OFS_STAT, 32'h0000_0003);
		apb(1'b1, OFS_CNT, 32'h0);
		apb(1'b0, OFS_STAT, 32'h0);
		chk(rd, {31'h0, e_z});
		apb(1'b0, OFS_CNT, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, 12'h081, 32'h0000_0077);
		chk(err, 1'b1);
		for (int i = 0; i < FILE_N; i++) begin
			apb(1'b0, OFS_FILE_BASE + ADDR_W'(4 * i), 32'h0);
			chk(rd, {24'h0, e_f[i]});
		end
		summarize();
	end
endmodule : move_and_nop_instruction_exec_bench
